// ==== logic/dwt_regs.vh ====
// Register offsets, field positions and reset values of the debug/tile bank
`ifndef DWT_REGS_VH
`define DWT_REGS_VH
`define DWT_IDX_W 8
`define DWT_OFS_PROTECT 8'h04
`define DWT_OFS_CAUSE 8'h05
`define DWT_OFS_CLKDIV 8'h06
`define DWT_OFS_SECURITY 8'h07
`define DWT_OFS_LINK 8'h10
`define DWT_OFS_SCRATCH 8'h20
`define DWT_OFS_CORE0_PC 8'h40
`define DWT_OFS_WLO 8'h50
`define DWT_OFS_WHI 8'h60
`define DWT_OFS_WCTL 8'h70
`define DWT_OFS_RMASK 8'h80
`define DWT_BIT_PROTECT 0
`define DWT_BIT_DBG_REQ 0
`define DWT_BIT_DBG_MODE 1
`define DWT_CLKDIV_W 8
`define DWT_WCTL_EN 0
`define DWT_WCTL_INV 1
`define DWT_WCTL_LOAD 2
`define DWT_WCTL_CORE_LO 16
`define DWT_WCTL_CORE_HI 23
`define DWT_LINK_MASK 32'h03FF_0037
`define DWT_RESET_WORD 32'h0000_0000
`endif

// ==== logic/dwt_watch_match.v ====
// Range and access-type matcher for one data watchpoint
`timescale 1ns/100ps
`include "dwt_regs.vh"
module dwt_watch_match #(
  parameter CORES = 8
) (
  input wire i_clock,
  input wire i_resetn,
  input wire [31:0] i_lower,
  input wire [31:0] i_upper,
  input wire [31:0] i_control,
  input wire i_access_valid,
  input wire i_access_store,
  input wire [31:0] i_access_addr,
  input wire [2:0] i_access_core,
  output reg o_hit
);
  wire in_range;
  wire out_range;
  wire type_ok;
  wire core_ok;
  wire [CORES-1:0] core_mask;
  reg nxt_hit;
  assign core_mask = i_control[`DWT_WCTL_CORE_LO +: CORES];
  // [R5] inclusive range
  assign in_range = (i_access_addr >= i_lower) && (i_access_addr <= i_upper);
  // [R6] outside open interval
  assign out_range = (i_access_addr > i_upper) ||
                     (i_access_addr < i_lower);
  // [R4] stores always, loads if enabled
  assign type_ok = i_access_store || i_control[`DWT_WCTL_LOAD];
  // [R3] per-core enable
  assign core_ok = core_mask[i_access_core];
  always @* begin
    nxt_hit = 1'b0;
    // [R7] watchpoint enable gate
    if (i_access_valid && i_control[`DWT_WCTL_EN] && type_ok && core_ok) begin
      nxt_hit = i_control[`DWT_WCTL_INV] ? out_range : in_range;
    end
  end
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hit <= 1'b0;
    end else begin
      o_hit <= nxt_hit;
    end
  end
endmodule

// ==== logic/dwt_cfg_bank.v ====
// Debug watchpoint and tile configuration register bank
// Notes on behaviour
// [R1] Four 32-bit lower-bound watchpoint address registers.
// [R2] Four 32-bit upper-bound watchpoint address registers.
// [R3] Control bits 23:16 enable each watchpoint per logical core; reset zero.
// [R4] Stores always checked; loads only when load-enable bit set.
// [R5] Invert clear: fire when address within both bounds inclusive.
// [R6] Invert set: fire when address outside open interval (upper, lower).
// [R7] Control bit zero enables the watchpoint; reset zero.
// [R8] Four resource watchpoint mask registers qualify resource matching.
// [R9] Protect bit makes switch-writable registers read-only from the switch; the clock divider write is not gated by it.
// [R10] Writing one to cause bit zero requests a debug interrupt.
// [R11] Cause bit one reads debug-mode state, read-only.
// [R12] Eight-bit divider field holds tile clock ratio minus one.
// [R13] Divider applies only when tile control enables it.
// [R14] Read-only security word copied from one-time memory.
// [R15] Link status bits 25:24 give source target type.
// [R16] Link status bits 23:16 give channel endpoint or idle indication.
// [R17] Link status bits 5:4 give network identifier.
// [R18] Link status bit 2 flags a junk packet being discarded.
// [R19] Link status bit 1: switch routing into link from another link.
// [R20] Link status bit 0: link routing into switch to another link.
// [R21] Eight scratch words shared with the processor status bank.
// [R22] Read-only program counter of logical core zero.
// [R23] Debug-writable registers accept writes only in debug mode.
// [R24] Reserved bits read zero; writes to them ignored.
`timescale 1ns/100ps
`include "dwt_regs.vh"
module dwt_cfg_bank #(
  parameter WATCH = 4,
  parameter LINKS = 4,
  parameter SCRATCH = 8,
  parameter CORES = 8
) (
  input wire i_clock,
  input wire i_resetn,
  // Configuration access from the processor switch
  input wire i_sw_req,
  input wire i_sw_write,
  input wire [`DWT_IDX_W-1:0] i_sw_addr,
  input wire [31:0] i_sw_wdata,
  output reg [31:0] o_sw_rdata,
  output reg o_sw_ack,
  // Processor status side access to the shared scratch words
  input wire i_ps_req,
  input wire i_ps_write,
  input wire [2:0] i_ps_index,
  input wire [31:0] i_ps_wdata,
  output reg [31:0] o_ps_rdata,
  // Core state
  input wire i_debug_mode,
  input wire i_divider_enable,
  input wire [31:0] i_security_word,
  input wire [31:0] i_core0_pc,
  input wire [LINKS*32-1:0] i_link_status,
  // Data access to watch
  input wire i_access_valid,
  input wire i_access_store,
  input wire [31:0] i_access_addr,
  input wire [2:0] i_access_core,
  output reg [WATCH-1:0] o_watch_hit,
  output reg [WATCH*32-1:0] o_resource_mask,
  output reg o_debug_irq_req,
  output reg [`DWT_CLKDIV_W-1:0] o_clock_divide,
  output reg o_switch_protect
);
  reg [31:0] wlo_ff [0:WATCH-1];
  reg [31:0] whi_ff [0:WATCH-1];
  reg [31:0] wctl_ff [0:WATCH-1];
  reg [31:0] rmask_ff [0:WATCH-1];
  reg [31:0] scratch_ff [0:SCRATCH-1];
  reg protect_ff;
  reg dbg_req_ff;
  reg [`DWT_CLKDIV_W-1:0] div_ff;
  reg dbg_mode_ff;
  reg dbg_mode_s1_ff;
  reg div_en_ff;
  reg div_en_s1_ff;
  reg [31:0] nxt_rdata;
  wire [WATCH-1:0] hit;
  wire wr;
  wire sw_wr_ok;
  wire dbg_wr_ok;
  wire [7:0] wctl_base;
  integer k;
  integer j;
  integer m;

  assign wr = i_sw_req && i_sw_write;
  // [R9] switch-writable locked by protect
  assign sw_wr_ok = wr && !protect_ff;
  // [R23] debug-writable only in debug mode
  assign dbg_wr_ok = wr && dbg_mode_ff;
  assign wctl_base = `DWT_OFS_WCTL;

  // Core state levels come from another clock region
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      dbg_mode_s1_ff <= 1'b0;
      dbg_mode_ff <= 1'b0;
      div_en_s1_ff <= 1'b0;
      div_en_ff <= 1'b0;
    end else begin
      dbg_mode_s1_ff <= i_debug_mode;
      dbg_mode_ff <= dbg_mode_s1_ff;
      div_en_s1_ff <= i_divider_enable;
      div_en_ff <= div_en_s1_ff;
    end
  end

  genvar g;
  generate
    for (g = 0; g < WATCH; g = g + 1) begin : g_watch
      always @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
          wlo_ff[g] <= `DWT_RESET_WORD;
          whi_ff[g] <= `DWT_RESET_WORD;
          wctl_ff[g] <= `DWT_RESET_WORD;
          rmask_ff[g] <= `DWT_RESET_WORD;
        end else if (dbg_wr_ok) begin
          // [R1] lower bound store
          if (i_sw_addr == `DWT_OFS_WLO + g) begin
            wlo_ff[g] <= i_sw_wdata;
          end
          // [R2] upper bound store
          if (i_sw_addr == `DWT_OFS_WHI + g) begin
            whi_ff[g] <= i_sw_wdata;
          end
          // [R24] only defined control bits kept
          if (i_sw_addr == wctl_base + g) begin
            wctl_ff[g] <= {8'h00,
              i_sw_wdata[`DWT_WCTL_CORE_HI:`DWT_WCTL_CORE_LO], 13'h0000,
              i_sw_wdata[`DWT_WCTL_LOAD:`DWT_WCTL_EN]};
          end
          // [R8] resource mask store
          if (i_sw_addr == `DWT_OFS_RMASK + g) begin
            rmask_ff[g] <= i_sw_wdata;
          end
        end
      end
      dwt_watch_match #(
        .CORES(CORES)
      ) u_match (
        .i_clock(i_clock),
        .i_resetn(i_resetn),
        .i_lower(wlo_ff[g]),
        .i_upper(whi_ff[g]),
        .i_control(wctl_ff[g]),
        .i_access_valid(i_access_valid),
        .i_access_store(i_access_store),
        .i_access_addr(i_access_addr),
        .i_access_core(i_access_core),
        .o_hit(hit[g])
      );
    end
  endgenerate

  // [R21] one storage, two access paths
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      for (k = 0; k < SCRATCH; k = k + 1) begin
        scratch_ff[k] <= `DWT_RESET_WORD;
      end
    end else begin
      for (k = 0; k < SCRATCH; k = k + 1) begin
        // Switch write wins if both sides hit the same word
        if (sw_wr_ok && i_sw_addr == `DWT_OFS_SCRATCH + k) begin
          scratch_ff[k] <= i_sw_wdata;
        end else if (i_ps_req && i_ps_write && i_ps_index == k) begin
          scratch_ff[k] <= i_ps_wdata;
        end
      end
    end
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      protect_ff <= 1'b0;
      dbg_req_ff <= 1'b0;
      div_ff <= {`DWT_CLKDIV_W{1'b0}};
    end else begin
      // [R9] protect bit locks itself too
      if (sw_wr_ok && i_sw_addr == `DWT_OFS_PROTECT) begin
        protect_ff <= i_sw_wdata[`DWT_BIT_PROTECT];
      end
      // [R10] debug interrupt request
      if (sw_wr_ok && i_sw_addr == `DWT_OFS_CAUSE) begin
        dbg_req_ff <= i_sw_wdata[`DWT_BIT_DBG_REQ];
      end
      // [R12] divide ratio minus one
      if (wr && i_sw_addr == `DWT_OFS_CLKDIV) begin
        div_ff <= i_sw_wdata[`DWT_CLKDIV_W-1:0];
      end
    end
  end

  always @* begin
    nxt_rdata = 32'h0000_0000;
    for (j = 0; j < WATCH; j = j + 1) begin
      if (i_sw_addr == `DWT_OFS_WLO + j) begin
        nxt_rdata = wlo_ff[j];
      end
      if (i_sw_addr == `DWT_OFS_WHI + j) begin
        nxt_rdata = whi_ff[j];
      end
      if (i_sw_addr == wctl_base + j) begin
        nxt_rdata = wctl_ff[j];
      end
      if (i_sw_addr == `DWT_OFS_RMASK + j) begin
        nxt_rdata = rmask_ff[j];
      end
    end
    for (j = 0; j < LINKS; j = j + 1) begin
      // [R15] [R16] [R17] [R18] [R19] [R20] link status fields, rest zero
      if (i_sw_addr == `DWT_OFS_LINK + j) begin
        nxt_rdata = i_link_status[j*32 +: 32] & `DWT_LINK_MASK;
      end
    end
    for (j = 0; j < SCRATCH; j = j + 1) begin
      if (i_sw_addr == `DWT_OFS_SCRATCH + j) begin
        nxt_rdata = scratch_ff[j];
      end
    end
    case (i_sw_addr)
      `DWT_OFS_PROTECT: nxt_rdata = {31'h0000_0000, protect_ff};
      // [R11] debug mode readback
      `DWT_OFS_CAUSE: nxt_rdata = {30'h0000_0000, dbg_mode_ff, dbg_req_ff};
      `DWT_OFS_CLKDIV: nxt_rdata = {24'h00_0000, div_ff};
      // [R14] security copy
      `DWT_OFS_SECURITY: nxt_rdata = i_security_word;
      // [R22] core zero program counter
      `DWT_OFS_CORE0_PC: nxt_rdata = i_core0_pc;
      default: nxt_rdata = nxt_rdata;
    endcase
  end

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_sw_rdata <= 32'h0000_0000;
      o_sw_ack <= 1'b0;
      o_ps_rdata <= 32'h0000_0000;
      o_watch_hit <= {WATCH{1'b0}};
      o_debug_irq_req <= 1'b0;
      o_clock_divide <= {`DWT_CLKDIV_W{1'b0}};
      o_switch_protect <= 1'b0;
      o_resource_mask <= {WATCH*32{1'b0}};
    end else begin
      o_sw_ack <= i_sw_req;
      if (i_sw_req && !i_sw_write) begin
        o_sw_rdata <= nxt_rdata;
      end
      if (i_ps_req && !i_ps_write) begin
        o_ps_rdata <= scratch_ff[i_ps_index];
      end
      o_watch_hit <= hit;
      o_debug_irq_req <= dbg_req_ff;
      // [R13] ratio one unless divider enabled
      o_clock_divide <= div_en_ff ? div_ff : {`DWT_CLKDIV_W{1'b0}};
      o_switch_protect <= protect_ff;
      // Registered so the mask output is glitch free
      for (m = 0; m < WATCH; m = m + 1) begin
        o_resource_mask[m*32 +: 32] <= rmask_ff[m];
      end
    end
  end
endmodule

// ==== bench/dwt_cfg_bank_monitor.sv ====
// Port-level checker for the debug/tile configuration bank
`timescale 1ns/100ps
module dwt_cfg_bank_monitor #(
  parameter LINKS = 4,
  parameter WATCH = 4
) (
  input wire i_clock,
  input wire i_resetn,
  input wire i_sw_req,
  input wire i_sw_write,
  input wire [7:0] i_sw_addr,
  input wire [31:0] i_sw_wdata,
  input wire [31:0] o_sw_rdata,
  input wire o_sw_ack,
  input wire i_divider_enable,
  input wire [31:0] i_security_word,
  input wire [31:0] i_core0_pc,
  input wire [LINKS*32-1:0] i_link_status,
  input wire i_access_valid,
  input wire [WATCH-1:0] o_watch_hit,
  input wire o_debug_irq_req,
  input wire [7:0] o_clock_divide,
  input wire o_switch_protect
);
  wire [31:0] link0 = i_link_status[31:0];
  wire wd0 = i_sw_wdata[0];
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_rd(a);
    i_sw_req && !i_sw_write && i_sw_addr == a;
  endsequence
  sequence s_wr(a);
    i_sw_req && i_sw_write && i_sw_addr == a;
  endsequence
  property p_ack; i_sw_req |=> o_sw_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_no_ack; !i_sw_req |=> !o_sw_ack; endproperty
  a_no_ack: assert property (p_no_ack) else $error("stray ack");
  property p_hold; !(i_sw_req && !i_sw_write) |=> $stable(o_sw_rdata);
  endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_sec; s_rd(8'h07) |=> o_sw_rdata == $past(i_security_word);
  endproperty
  a_sec: assert property (p_sec) else $error("bad security");
  property p_pc; s_rd(8'h40) |=> o_sw_rdata == $past(i_core0_pc);
  endproperty
  a_pc: assert property (p_pc) else $error("bad pc");
  property p_link;
    s_rd(8'h10) |=> o_sw_rdata == ($past(link0) & 32'h03FF_0037);
  endproperty
  a_link: assert property (p_link) else $error("bad link word");
  property p_irq;
    (i_sw_req && i_sw_write && i_sw_addr == 8'h05 && !o_switch_protect)
      |=> ##1 o_debug_irq_req == $past(wd0, 2);
  endproperty
  a_irq: assert property (p_irq) else $error("bad irq");
  property p_div_off; !i_divider_enable [*4] |=> o_clock_divide == 8'h00;
  endproperty
  a_div_off: assert property (p_div_off) else $error("div on");
  property p_hit; o_watch_hit != 0 |-> $past(i_access_valid, 2); endproperty
  a_hit: assert property (p_hit) else $error("hit no access");
  property p_prot; o_switch_protect |=> o_switch_protect; endproperty
  a_prot: assert property (p_prot) else $error("protect lost");
endmodule
bind dwt_cfg_bank dwt_cfg_bank_monitor #(.LINKS(LINKS), .WATCH(WATCH)) mon_i (
  .i_clock, .i_resetn, .i_sw_req, .i_sw_write, .i_sw_addr, .i_sw_wdata,
  .o_sw_rdata, .o_sw_ack, .i_divider_enable, .i_security_word, .i_core0_pc,
  .i_link_status, .i_access_valid, .o_watch_hit, .o_debug_irq_req,
  .o_clock_divide, .o_switch_protect);

// ==== bench/dwt_core_model.sv ====
// Tile core stand-in: enters debug mode after a debug request
`timescale 1ns/100ps
module dwt_core_model #(
  parameter DELAY = 3
) (
  input wire i_clock,
  input wire i_resetn,
  input wire i_debug_irq_req,
  output wire o_debug_mode
);
  reg [DELAY-1:0] pipe_ff;
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) pipe_ff <= '0;
    else pipe_ff <= {pipe_ff[DELAY-2:0], i_debug_irq_req};
  end
  assign o_debug_mode = pipe_ff[DELAY-1];
endmodule

// ==== bench/dwt_cfg_bank_bench.sv ====
// Self-checking bench for the debug/tile configuration bank
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module dwt_cfg_bank_bench;
  reg clk = 0, rstn = 0, req = 0, wr = 0, psr = 0, psw = 0, den = 0;
  reg av = 0, ast = 0;
  reg [7:0] adr = 0;
  reg [31:0] wd = 0, pwd = 0, aad = 0, rd, sec = 32'hA5C3_0F1E;
  reg [31:0] pc = 32'h0000_4F2C;
  reg [2:0] pix = 0, acr = 0;
  reg [127:0] lnk = {32'hFFFF_FFFF, 64'h0, 32'h5AC3_0004};
  wire [31:0] srd, prd;
  wire [3:0] hit;
  wire [127:0] rmask;
  wire ack, irq, prot, dmode;
  wire [7:0] cdiv;
  integer errors = 0, tests_run = 0;
  dwt_cfg_bank dwt_cfg_bank_i (.i_clock(clk), .i_resetn(rstn),
    .i_sw_req(req), .i_sw_write(wr), .i_sw_addr(adr), .i_sw_wdata(wd),
    .o_sw_rdata(srd), .o_sw_ack(ack), .i_ps_req(psr), .i_ps_write(psw),
    .i_ps_index(pix), .i_ps_wdata(pwd), .o_ps_rdata(prd),
    .i_debug_mode(dmode), .i_divider_enable(den), .i_security_word(sec),
    .i_core0_pc(pc), .i_link_status(lnk), .i_access_valid(av),
    .i_access_store(ast), .i_access_addr(aad), .i_access_core(acr),
    .o_watch_hit(hit), .o_resource_mask(rmask), .o_debug_irq_req(irq),
    .o_clock_divide(cdiv), .o_switch_protect(prot));
  dwt_core_model dwt_core_model_i (.i_clock(clk), .i_resetn(rstn),
    .i_debug_irq_req(irq), .o_debug_mode(dmode));
  initial forever #2 clk = ~clk;
  task sw(input w, input [7:0] a, input [31:0] d);
    @(negedge clk);
    req = 1; wr = w; adr = a; wd = d;
    @(negedge clk);
    req = 0;
    @(negedge clk);
    rd = srd;
  endtask
  task ps(input w, input [2:0] i, input [31:0] d);
    @(negedge clk);
    psr = 1; psw = w; pix = i; pwd = d;
    @(negedge clk);
    psr = 0;
    @(negedge clk);
  endtask
  task acc(input s, input [31:0] a, input [2:0] c, input e);
    @(negedge clk);
    av = 1; ast = s; aad = a; acr = c;
    @(negedge clk);
    av = 0;
    @(negedge clk);
    `CHK("hit", e, hit[0])
  endtask
  task t_reset;
    integer i;
    for (i = 0; i < 8; i++) begin
      sw(0, 64'h0405_0650_6070_8020 >> (56 - 8 * i), 0);
      `CHK("reset", 32'h0000_0000, rd)
    end
  endtask
  task t_ro;
    sw(1, 8'h07, 32'h0000_0000); sw(0, 8'h07, 0);
    `CHK("sec", sec, rd)
    sw(0, 8'h40, 0); `CHK("pc", pc, rd)
    sw(0, 8'h10, 0); `CHK("link0", 32'h02C3_0004, rd)
    sw(0, 8'h13, 0); `CHK("link3", 32'h03FF_0037, rd)
    sw(0, 8'h90, 0); `CHK("unmapped", 32'h0000_0000, rd)
  endtask
  task t_scratch;
    sw(1, 8'h23, 32'hDEAD_BEEF); ps(0, 3, 0);
    `CHK("ps side", 32'hDEAD_BEEF, prd)
    ps(1, 7, 32'h1357_9BDF); sw(0, 8'h27, 0);
    `CHK("sw side", 32'h1357_9BDF, rd)
  endtask
  task t_div;
    den = 1; sw(1, 8'h06, 32'hFFFF_FF05); repeat (4) @(negedge clk);
    `CHK("div", 8'h05, cdiv)
    sw(0, 8'h06, 0); `CHK("div reg", 32'h0000_0005, rd)
    den = 0; repeat (5) @(negedge clk);
    `CHK("div off", 8'h00, cdiv)
  endtask
  task t_debug;
    sw(1, 8'h50, 32'h0000_1111); sw(0, 8'h50, 0);
    `CHK("dbg only", 32'h0000_0000, rd)
    sw(1, 8'h05, 32'h0000_0001); repeat (2) @(negedge clk);
    `CHK("irq", 1'b1, irq)
    repeat (8) @(negedge clk);
    sw(0, 8'h05, 0); `CHK("cause", 32'h0000_0003, rd)
    sw(1, 8'h50, 32'h0000_0100); sw(1, 8'h60, 32'h0000_0200);
    sw(0, 8'h60, 0); `CHK("upper", 32'h0000_0200, rd)
    sw(1, 8'h83, 32'hCAFE_F00D);
    `CHK("mask", 32'hCAFE_F00D, rmask[127:96])
  endtask
  task t_watch;
    sw(1, 8'h70, 32'h0001_0001);
    acc(1, 32'h0000_0100, 0, 1);
    acc(1, 32'h0000_0200, 0, 1);
    acc(1, 32'h0000_0201, 0, 0);
    acc(0, 32'h0000_0150, 0, 0);
    acc(1, 32'h0000_0150, 1, 0);
    sw(1, 8'h70, 32'h0001_0005); acc(0, 32'h0000_0150, 0, 1);
    sw(1, 8'h70, 32'h0001_0007); acc(1, 32'h0000_0300, 0, 1);
    acc(1, 32'h0000_0150, 0, 0);
    acc(1, 32'h0000_0200, 0, 0);
    sw(1, 8'h70, 32'h0001_0006); acc(1, 32'h0000_0300, 0, 0);
  endtask
  task t_protect;
    sw(1, 8'h04, 32'h0000_0001); sw(1, 8'h24, 32'h0000_0001);
    sw(0, 8'h24, 0); `CHK("locked", 32'h0000_0000, rd)
    sw(1, 8'h04, 32'h0000_0000); sw(0, 8'h04, 0);
    `CHK("self", 32'h0000_0001, rd)
  endtask
  task results;
    if (errors == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge clk);
    rstn = 1;
    t_reset; t_ro; t_scratch; t_div; t_debug; t_watch; t_protect;
    results;
  end
  // Whole run needs well under 1000 cycles
  initial begin
    #20000;
    errors++;
    results;
  end
endmodule
